/* File: common/rtsc_pkg.sv */
// Constants and types of the reset, timer and system control block
package rtsc_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SWRST = 8'h04;
  localparam logic [7:0] OFF_WD_LOCK = 8'h08;
  localparam logic [7:0] OFF_WD_CTRL = 8'h0c;
  localparam logic [7:0] OFF_WD_LOAD = 8'h10;
  localparam logic [7:0] OFF_WD_KICK = 8'h14;
  localparam logic [7:0] OFF_WD_COUNT = 8'h18;
  localparam logic [7:0] OFF_GPT_CTRL = 8'h1c;
  localparam logic [7:0] OFF_GPT_LOAD = 8'h20;
  localparam logic [7:0] OFF_GPT_COUNT = 8'h24;
  localparam logic [7:0] OFF_WUT_CTRL = 8'h28;
  localparam logic [7:0] OFF_WUT_LOAD = 8'h2c;
  localparam logic [7:0] OFF_WUT_COUNT = 8'h30;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h34;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h38;
  localparam logic [7:0] OFF_RST_CAUSE = 8'h3c;

  // Field positions
  localparam int unsigned CTRL_HS_SEL_BIT = 0;
  localparam int unsigned CTRL_PMODE_LSB = 2;
  localparam int unsigned SWRST_REQ_BIT = 0;
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned GPT_RELOAD_BIT = 1;
  localparam int unsigned GPT_SRC_BIT = 2;
  localparam int unsigned GPT_PRE_LSB = 8;
  localparam int unsigned EVT_GPT_BIT = 0;
  localparam int unsigned EVT_WUT_BIT = 1;
  localparam int unsigned EVT_ATTACH_BIT = 2;
  localparam int unsigned CAUSE_POR_BIT = 0;
  localparam int unsigned CAUSE_SW_BIT = 1;
  localparam int unsigned CAUSE_WD_BIT = 2;

  // Keys, arbitrary values
  localparam logic [31:0] WD_UNLOCK_KEY = 32'h0000_c0de;
  localparam logic [31:0] WD_KICK_KEY = 32'h0000_a5a5;

  // Reset values
  localparam logic CTRL_HS_SEL_RST = 1'b1;
  localparam logic [31:0] WD_LOAD_RST = 32'h00ff_ffff;
  localparam logic [31:0] TMR_LOAD_RST = 32'h0000_0000;
  localparam logic [7:0] GPT_PRE_RST = 8'h00;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned RST_HOLD_NS = 200;
  localparam int unsigned RST_HOLD_CYC =
    (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_SLEEP} rtsc_pmode_t;

  typedef struct packed {
    logic core;
    logic debug;
    logic periph;
    logic wakeup;
    logic wdog;
  } rtsc_dom_rst_t;

endpackage : rtsc_pkg

/* File: rtl/rtsc_top.sv */
// Reset merging, watchdog, timers, oscillator and power mode control
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps

// Operation
// - Low supply resets every domain
// - Software reset spares debug domain
// - Watchdog reset spares wake-up timer
// - 32-bit watchdog resets system on timeout
// - Watchdog starts disabled until software enables
// - Watchdog never pauses for debug halt
// - Watchdog controls need unlock key first
// - Watchdog runs on selected core clock
// - 32-bit down-counter flags interrupt at zero
// - Timer ticks from source and prescaler
// - 32-bit wake-up timer ends low power
// - Select high or low speed oscillator
// - Power modes, wake on unmasked interrupt
// - Attach detection wakes from sleep unless a CTRL write sets the mode in the same cycle
// - Registers reached over peripheral register port
module rtsc_top #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // System inputs
  input wire logic supply_ok,
  input wire logic ls_tick,
  input wire logic attach_detect,
  // Reset domains
  output rtsc_pkg::rtsc_dom_rst_t rst_out,
  // Clock and power control
  output logic core_clk_sel_hs,
  output logic hs_osc_en,
  output rtsc_pkg::rtsc_pmode_t pmode,
  output logic wake_req,
  // Interrupt
  output logic irq
);

  function automatic logic [31:0] cnt_step(input logic [31:0] cnt,
                                           input logic [31:0] load,
                                           input logic tick,
                                           input logic reload);
    if (!tick) begin
      return cnt;
    end
    if (cnt == 32'h0000_0000) begin
      return reload ? load : cnt;
    end
    return cnt - 32'h0000_0001;
  endfunction : cnt_step

  function automatic logic hits_zero(input logic [31:0] cnt,
                                     input logic tick);
    return tick && (cnt == 32'h0000_0001);
  endfunction : hits_zero

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a,
                                  input logic [7:0] off,
                                  input logic wr);
    return wr && (a == ADDR_W'(off));
  endfunction : wr_hit

  // State
  logic sw_act;
  logic wd_act;
  logic [7:0] hold_cnt;
  logic hs_sel;
  logic wd_en;
  logic wd_unlocked;
  logic [31:0] wd_load;
  logic [31:0] wd_cnt;
  logic gpt_en;
  logic gpt_reload;
  logic gpt_src;
  logic [7:0] gpt_pre;
  logic [7:0] pre_cnt;
  logic [31:0] gpt_load;
  logic [31:0] gpt_cnt;
  logic wut_en;
  logic [31:0] wut_load;
  logic [31:0] wut_cnt;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] rst_cause;

  // Reset causes and domains
  wire por_act = !supply_ok;
  wire dom_core = por_act || sw_act || wd_act;
  wire dom_dbg = por_act || wd_act;
  wire dom_wut = por_act || sw_act;
  wire dom_wd = dom_core;
  wire dom_per = dom_core;

  // Register decode
  wire wr_ctrl = wr_hit(reg_addr, rtsc_pkg::OFF_CTRL, reg_wr);
  wire wr_swrst = wr_hit(reg_addr, rtsc_pkg::OFF_SWRST, reg_wr);
  wire wr_lock = wr_hit(reg_addr, rtsc_pkg::OFF_WD_LOCK, reg_wr);
  wire wr_wdc = wr_hit(reg_addr, rtsc_pkg::OFF_WD_CTRL, reg_wr);
  wire wr_wdl = wr_hit(reg_addr, rtsc_pkg::OFF_WD_LOAD, reg_wr);
  wire wr_kick = wr_hit(reg_addr, rtsc_pkg::OFF_WD_KICK, reg_wr);
  wire wr_gptc = wr_hit(reg_addr, rtsc_pkg::OFF_GPT_CTRL, reg_wr);
  wire wr_gptl = wr_hit(reg_addr, rtsc_pkg::OFF_GPT_LOAD, reg_wr);
  wire wr_wutc = wr_hit(reg_addr, rtsc_pkg::OFF_WUT_CTRL, reg_wr);
  wire wr_wutl = wr_hit(reg_addr, rtsc_pkg::OFF_WUT_LOAD, reg_wr);
  wire wr_mask = wr_hit(reg_addr, rtsc_pkg::OFF_IRQ_MASK, reg_wr);
  wire rd_status = wr_hit(reg_addr, rtsc_pkg::OFF_IRQ_STATUS, reg_rd);
  wire rd_cause = wr_hit(reg_addr, rtsc_pkg::OFF_RST_CAUSE, reg_rd);

  // Watchdog protection
  wire wd_prot_wr = (wr_wdc || wr_wdl) && wd_unlocked;
  wire wd_key_ok = wr_lock && (reg_wdata == rtsc_pkg::WD_UNLOCK_KEY);
  wire wd_kick = wr_kick && (reg_wdata == rtsc_pkg::WD_KICK_KEY);
  wire sw_req = wr_swrst && reg_wdata[rtsc_pkg::SWRST_REQ_BIT];

  // Counter ticks; watchdog has no halt term
  wire wd_timeout = hits_zero(wd_cnt, wd_en);
  wire pre_done = gpt_src ? ls_tick : 1'b1;
  wire gpt_tick = gpt_en && pre_done && (pre_cnt == gpt_pre);
  wire gpt_zero = hits_zero(gpt_cnt, gpt_tick);
  wire wut_zero = hits_zero(wut_cnt, wut_en);
  wire [2:0] evt_set = {attach_detect, wut_zero, gpt_zero};
  wire irq_pend = |(irq_status & irq_mask);
  wire wake_evt = wut_zero || attach_detect || irq_pend;

  // Next values
  wire [7:0] next_hold = (sw_req || wd_timeout) ?
                         8'(rtsc_pkg::RST_HOLD_CYC - 1) :
                         (hold_cnt != 8'h00) ? hold_cnt - 8'h01 : 8'h00;
  wire next_sw_act = sw_req || (sw_act && hold_cnt != 8'h00);
  wire next_wd_act = wd_timeout || (wd_act && hold_cnt != 8'h00);
  wire [31:0] next_wd_cnt = (wd_kick || (wd_prot_wr && wr_wdc)) ?
                            wd_load : cnt_step(wd_cnt, wd_load, wd_en, 1'b1);
  wire [31:0] next_gpt_cnt = wr_gptl ? reg_wdata :
                             cnt_step(gpt_cnt, gpt_load, gpt_tick,
                                      gpt_reload);
  wire [31:0] next_wut_cnt = wr_wutl ? reg_wdata :
                             cnt_step(wut_cnt, wut_load, wut_en, 1'b1);
  wire [7:0] next_pre_cnt = (!gpt_en || gpt_tick) ? 8'h00 :
                            pre_done ? pre_cnt + 8'h01 : pre_cnt;
  wire [2:0] next_status = (rd_status ? 3'h0 : irq_status) | evt_set;
  wire [2:0] next_cause = (rd_cause ? 3'h0 : rst_cause) |
                          {wd_act, sw_act, por_act};
  wire [1:0] wr_pmode = reg_wdata[rtsc_pkg::CTRL_PMODE_LSB +: 2];
  wire rtsc_pkg::rtsc_pmode_t next_pmode =
    (wr_ctrl && wr_pmode != 2'h3) ? rtsc_pkg::rtsc_pmode_t'(wr_pmode) :
    (pmode != rtsc_pkg::PM_RUN && wake_evt) ? rtsc_pkg::PM_RUN : pmode;

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr)
      ADDR_W'(rtsc_pkg::OFF_CTRL): rd_mux = {28'h0, pmode, 1'b0, hs_sel};
      ADDR_W'(rtsc_pkg::OFF_WD_LOCK): rd_mux = {31'h0, wd_unlocked};
      ADDR_W'(rtsc_pkg::OFF_WD_CTRL): rd_mux = {31'h0, wd_en};
      ADDR_W'(rtsc_pkg::OFF_WD_LOAD): rd_mux = wd_load;
      ADDR_W'(rtsc_pkg::OFF_WD_COUNT): rd_mux = wd_cnt;
      ADDR_W'(rtsc_pkg::OFF_GPT_CTRL): rd_mux =
        {16'h0, gpt_pre, 5'h0, gpt_src, gpt_reload, gpt_en};
      ADDR_W'(rtsc_pkg::OFF_GPT_LOAD): rd_mux = gpt_load;
      ADDR_W'(rtsc_pkg::OFF_GPT_COUNT): rd_mux = gpt_cnt;
      ADDR_W'(rtsc_pkg::OFF_WUT_CTRL): rd_mux = {31'h0, wut_en};
      ADDR_W'(rtsc_pkg::OFF_WUT_LOAD): rd_mux = wut_load;
      ADDR_W'(rtsc_pkg::OFF_WUT_COUNT): rd_mux = wut_cnt;
      ADDR_W'(rtsc_pkg::OFF_IRQ_STATUS): rd_mux = {29'h0, irq_status};
      ADDR_W'(rtsc_pkg::OFF_IRQ_MASK): rd_mux = {29'h0, irq_mask};
      ADDR_W'(rtsc_pkg::OFF_RST_CAUSE): rd_mux = {29'h0, rst_cause};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Register port read data
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Reset causes and synchronous domain outputs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sw_act <= 1'b0;
      wd_act <= 1'b0;
      hold_cnt <= 8'h00;
      rst_out <= '1;
      rst_cause <= 3'h0;
    end else if (clk_en) begin
      sw_act <= next_sw_act;
      wd_act <= next_wd_act;
      hold_cnt <= next_hold;
      rst_out <= '{dom_core, dom_dbg, dom_per, dom_wut, dom_wd};
      rst_cause <= next_cause;
    end
  end

  // Watchdog
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wd_en <= 1'b0;
      wd_unlocked <= 1'b0;
      wd_load <= rtsc_pkg::WD_LOAD_RST;
      wd_cnt <= rtsc_pkg::WD_LOAD_RST;
    end else if (clk_en) begin
      if (dom_wd) begin
        wd_en <= 1'b0;
        wd_unlocked <= 1'b0;
        wd_load <= rtsc_pkg::WD_LOAD_RST;
        wd_cnt <= rtsc_pkg::WD_LOAD_RST;
      end else begin
        if (wd_prot_wr && wr_wdc) begin
          wd_en <= reg_wdata[rtsc_pkg::EN_BIT];
        end
        if (wd_prot_wr && wr_wdl) begin
          wd_load <= reg_wdata;
        end
        wd_unlocked <= wd_key_ok || (wd_unlocked && !wd_prot_wr);
        wd_cnt <= next_wd_cnt;
      end
    end
  end

  // Peripheral registers: clock, power mode, timer, interrupts
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hs_sel <= rtsc_pkg::CTRL_HS_SEL_RST;
      pmode <= rtsc_pkg::PM_RUN;
      gpt_en <= 1'b0;
      gpt_reload <= 1'b0;
      gpt_src <= 1'b0;
      gpt_pre <= rtsc_pkg::GPT_PRE_RST;
      pre_cnt <= 8'h00;
      gpt_load <= rtsc_pkg::TMR_LOAD_RST;
      gpt_cnt <= rtsc_pkg::TMR_LOAD_RST;
      irq_status <= 3'h0;
      irq_mask <= rtsc_pkg::IRQ_MASK_RST;
    end else if (clk_en) begin
      if (dom_per) begin
        hs_sel <= rtsc_pkg::CTRL_HS_SEL_RST;
        pmode <= rtsc_pkg::PM_RUN;
        gpt_en <= 1'b0;
        gpt_reload <= 1'b0;
        gpt_src <= 1'b0;
        gpt_pre <= rtsc_pkg::GPT_PRE_RST;
        pre_cnt <= 8'h00;
        gpt_load <= rtsc_pkg::TMR_LOAD_RST;
        gpt_cnt <= rtsc_pkg::TMR_LOAD_RST;
        irq_status <= 3'h0;
        irq_mask <= rtsc_pkg::IRQ_MASK_RST;
      end else begin
        if (wr_ctrl) begin
          hs_sel <= reg_wdata[rtsc_pkg::CTRL_HS_SEL_BIT];
        end
        pmode <= next_pmode;
        if (wr_gptc) begin
          gpt_en <= reg_wdata[rtsc_pkg::EN_BIT];
          gpt_reload <= reg_wdata[rtsc_pkg::GPT_RELOAD_BIT];
          gpt_src <= reg_wdata[rtsc_pkg::GPT_SRC_BIT];
          gpt_pre <= reg_wdata[rtsc_pkg::GPT_PRE_LSB +: 8];
        end
        if (wr_gptl) begin
          gpt_load <= reg_wdata;
        end
        pre_cnt <= next_pre_cnt;
        gpt_cnt <= next_gpt_cnt;
        irq_status <= next_status;
        if (wr_mask) begin
          irq_mask <= reg_wdata[2:0];
        end
      end
    end
  end

  // Wake-up timer, cleared by supply and software resets only
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wut_en <= 1'b0;
      wut_load <= rtsc_pkg::TMR_LOAD_RST;
      wut_cnt <= rtsc_pkg::TMR_LOAD_RST;
    end else if (clk_en) begin
      if (dom_wut) begin
        wut_en <= 1'b0;
        wut_load <= rtsc_pkg::TMR_LOAD_RST;
        wut_cnt <= rtsc_pkg::TMR_LOAD_RST;
      end else begin
        if (wr_wutc) begin
          wut_en <= reg_wdata[rtsc_pkg::EN_BIT];
        end
        if (wr_wutl) begin
          wut_load <= reg_wdata;
        end
        wut_cnt <= next_wut_cnt;
      end
    end
  end

  // Outputs
  assign core_clk_sel_hs = hs_sel && (pmode != rtsc_pkg::PM_SLEEP);
  assign hs_osc_en = core_clk_sel_hs;
  assign wake_req = (pmode != rtsc_pkg::PM_RUN) && wake_evt;
  assign irq = irq_pend;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  por_scope_a: assert property ((clk_en && !supply_ok) |=>
    (rst_out == '1)) else $error("supply reset scope wrong");
  sw_scope_a: assert property ((clk_en && sw_act && !wd_act &&
    supply_ok) |=> (!rst_out.debug && rst_out.wakeup && rst_out.core))
    else $error("software reset scope wrong");
  wd_scope_a: assert property ((clk_en && wd_act && !sw_act &&
    supply_ok) |=> (rst_out.debug && !rst_out.wakeup && rst_out.wdog))
    else $error("watchdog reset scope wrong");
  wd_fire_a: assert property ((clk_en && wd_en && wd_cnt == 32'h1 &&
    !dom_wd) |=> (wd_act && hold_cnt == 8'(rtsc_pkg::RST_HOLD_CYC - 1)))
    else $error("watchdog timeout lost");
  wd_off_a: assert property ((clk_en && dom_wd) |=> !wd_en)
    else $error("watchdog enabled under reset");
  wd_run_a: assert property ((clk_en && wd_en && !dom_wd && !wd_kick &&
    !wd_prot_wr && wd_cnt > 32'h1) |=> (wd_cnt == $past(wd_cnt) - 32'h1))
    else $error("watchdog did not count");
  wd_lock_a: assert property ((clk_en && wr_wdc && !wd_unlocked) |=>
    (wd_en == $past(wd_en))) else $error("locked write changed watchdog");
  wd_relock_a: assert property ((clk_en && wd_prot_wr && !dom_wd &&
    !wd_key_ok) |=> !wd_unlocked) else $error("lock did not re-engage");
  gpt_flag_a: assert property ((clk_en && gpt_tick &&
    gpt_cnt == 32'h1 && !dom_per) |=> (irq_status[rtsc_pkg::EVT_GPT_BIT]
    && gpt_cnt == 32'h0)) else $error("timer zero flag lost");
  wut_flag_a: assert property ((clk_en && wut_zero && !dom_wut &&
    !dom_per) |=> irq_status[rtsc_pkg::EVT_WUT_BIT])
    else $error("wake-up timer flag lost");
  attach_wake_a: assert property ((clk_en && attach_detect &&
    !dom_per && !wr_ctrl) |=> (pmode == rtsc_pkg::PM_RUN &&
    irq_status[rtsc_pkg::EVT_ATTACH_BIT]))
    else $error("attach did not wake");
  gpt_sticky_a: assert property ((clk_en &&
    irq_status[rtsc_pkg::EVT_GPT_BIT] && !rd_status && !dom_per) |=>
    irq_status[rtsc_pkg::EVT_GPT_BIT])
    else $error("timer flag dropped");
  wut_keep_a: assert property ((clk_en && wd_act && !sw_act &&
    supply_ok && wut_en && !wr_wutc) |=> wut_en)
    else $error("watchdog reset cleared wake-up timer");
  wut_reload_a: assert property ((clk_en && wut_en &&
    wut_cnt == 32'h0 && !dom_wut && !wr_wutl) |=>
    (wut_cnt == $past(wut_load))) else $error("wake-up timer no reload");
  wd_unlock_a: assert property ((clk_en && wd_key_ok &&
    !dom_wd) |=> wd_unlocked) else $error("key did not unlock");
  sw_request_a: assert property ((clk_en && sw_req) |=> sw_act)
    else $error("software reset request lost");
  rdata_idle_a: assert property ((clk_en && !reg_rd) |=>
    (reg_rdata == 32'h0)) else $error("read data without read");
  freeze_hold_a: assert property (!clk_en |=> ($stable(wd_cnt) &&
    $stable(wut_cnt) && $stable(gpt_cnt) && $stable(rst_out)))
    else $error("state moved while frozen");

  sw_reset_c: cover property (sw_act ##[1:8] !sw_act);
  wd_reset_c: cover property (wd_timeout ##1 wd_act);
  sleep_wake_c: cover property (pmode == rtsc_pkg::PM_SLEEP ##[1:20]
    pmode == rtsc_pkg::PM_RUN);
  gpt_irq_c: cover property (gpt_zero ##1 irq);
  idle_mode_c: cover property (pmode == rtsc_pkg::PM_IDLE);

endmodule : rtsc_top

/* File: tb/rtsc_core_model.sv */
// Core-side model that masters the register port
`timescale 1ns/1ps
module rtsc_core_model (
  // Clock
  input wire logic clock,
  // Register port
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Key first, then a single protected write
  task automatic wd_write(input logic [7:0] a, input logic [31:0] d);
    wr(rtsc_pkg::OFF_WD_LOCK, rtsc_pkg::WD_UNLOCK_KEY);
    wr(a, d);
  endtask : wd_write
endmodule : rtsc_core_model

/* File: tb/testbench.sv */
// Self-checking testbench of the reset and timer block
`timescale 1ns/1ps
module testbench;
  logic clock, sys_rst, clk_en, supply_ok, ls_tick, attach_detect;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, va, vb;
  logic reg_wr, reg_rd, core_clk_sel_hs, hs_osc_en, wake_req, irq, seen;
  rtsc_pkg::rtsc_dom_rst_t rst_out;
  rtsc_pkg::rtsc_pmode_t pmode;
  logic [2:0] tick_cnt;
  int err_total, n_compared, i;

  rtsc_top DUT (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .supply_ok(supply_ok),
    .ls_tick(ls_tick), .attach_detect(attach_detect), .rst_out(rst_out),
    .core_clk_sel_hs(core_clk_sel_hs), .hs_osc_en(hs_osc_en),
    .pmode(pmode), .wake_req(wake_req), .irq(irq));
  rtsc_core_model core (.clock(clock), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  always #25 clock = ~clock;

  // Low-speed tick every eight core cycles
  always @(posedge clock) begin
    tick_cnt <= tick_cnt + 3'h1;
    ls_tick <= (tick_cnt == 3'h7);
  end

  task automatic check_reg(string name, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", name, e, g);
    end
  endtask : check_reg

  task automatic check_pin(string name, logic [4:0] e, logic [4:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", name, e, g);
    end
  endtask : check_pin

  task automatic rd_chk(logic [7:0] a, logic [31:0] e, string name);
    logic [31:0] d;
    core.rd(a, d);
    check_reg(name, e, d);
  endtask : rd_chk

  task automatic wait_rst_clear();
    for (i = 0; i < 40 && rst_out !== 5'h00; i++) begin
      @(posedge clock);
      #1;
    end
  endtask : wait_rst_clear

  task automatic t_reset();
    check_pin("rst_out", 5'h00, rst_out);
    check_pin("clk_sel", 5'h01, {4'h0, core_clk_sel_hs});
    check_pin("osc_en", 5'h01, {4'h0, hs_osc_en});
    check_pin("pmode", 5'h00, {3'h0, pmode});
    rd_chk(rtsc_pkg::OFF_CTRL, 32'h1, "ctrl");
    rd_chk(rtsc_pkg::OFF_WD_CTRL, 32'h0, "wd_ctrl");
    rd_chk(rtsc_pkg::OFF_WD_LOAD, 32'h00ff_ffff, "wd_load");
    rd_chk(8'h40, 32'h0, "unmapped");
    core.rd(rtsc_pkg::OFF_RST_CAUSE, va);
    $display("test reset done");
  endtask : t_reset

  task automatic t_wd_lock();
    core.wr(rtsc_pkg::OFF_WD_CTRL, 32'h1);
    rd_chk(rtsc_pkg::OFF_WD_CTRL, 32'h0, "wd_ctrl locked");
    core.wr(rtsc_pkg::OFF_WD_LOCK, 32'h0000_1234);
    core.wr(rtsc_pkg::OFF_WD_CTRL, 32'h1);
    rd_chk(rtsc_pkg::OFF_WD_CTRL, 32'h0, "wd_ctrl bad key");
    core.rd(rtsc_pkg::OFF_WD_COUNT, va);
    core.rd(rtsc_pkg::OFF_WD_COUNT, vb);
    check_reg("wd idle count", va, vb);
    core.wd_write(rtsc_pkg::OFF_WD_LOAD, 32'h28);
    rd_chk(rtsc_pkg::OFF_WD_LOAD, 32'h28, "wd_load open");
    rd_chk(rtsc_pkg::OFF_WD_LOCK, 32'h0, "wd_lock relock");
    core.wr(rtsc_pkg::OFF_WD_LOAD, 32'h5);
    rd_chk(rtsc_pkg::OFF_WD_LOAD, 32'h28, "wd_load relocked");
    $display("test watchdog lock done");
  endtask : t_wd_lock

  task automatic t_wd_timeout();
    core.wr(rtsc_pkg::OFF_WUT_LOAD, 32'h400);
    core.wr(rtsc_pkg::OFF_WUT_CTRL, 32'h1);
    core.wd_write(rtsc_pkg::OFF_WD_CTRL, 32'h1);
    core.rd(rtsc_pkg::OFF_WD_COUNT, va);
    core.rd(rtsc_pkg::OFF_WD_COUNT, vb);
    check_reg("wd step", va - 32'h2, vb);
    core.wr(rtsc_pkg::OFF_WD_KICK, rtsc_pkg::WD_KICK_KEY);
    rd_chk(rtsc_pkg::OFF_WD_COUNT, 32'h27, "wd kick");
    for (i = 0; i < 60 && rst_out.wdog !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check_pin("wd scope", 5'b11101, rst_out);
    wait_rst_clear();
    rd_chk(rtsc_pkg::OFF_RST_CAUSE, 32'h4, "cause wd");
    rd_chk(rtsc_pkg::OFF_WD_CTRL, 32'h0, "wd off again");
    rd_chk(rtsc_pkg::OFF_WUT_CTRL, 32'h1, "wut kept");
    core.wr(rtsc_pkg::OFF_WUT_CTRL, 32'h0);
    $display("test watchdog timeout done");
  endtask : t_wd_timeout

  task automatic t_swrst();
    core.wr(rtsc_pkg::OFF_SWRST, 32'h1);
    for (i = 0; i < 10 && rst_out.core !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check_pin("sw scope", 5'b10111, rst_out);
    for (i = 0; i < 10 && rst_out.core === 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check_pin("sw hold", 5'h04, i[4:0]);
    wait_rst_clear();
    rd_chk(rtsc_pkg::OFF_RST_CAUSE, 32'h2, "cause sw");
    $display("test software reset done");
  endtask : t_swrst

  task automatic t_gpt();
    core.wr(rtsc_pkg::OFF_IRQ_MASK, 32'h1);
    core.wr(rtsc_pkg::OFF_GPT_LOAD, 32'h3);
    core.wr(rtsc_pkg::OFF_GPT_CTRL, 32'h5);
    repeat (12) @(posedge clock);
    #1;
    check_pin("irq early", 5'h00, {4'h0, irq});
    for (i = 0; i < 40 && irq !== 1'b1; i++) @(posedge clock);
    #1;
    check_pin("irq gpt", 5'h01, {4'h0, irq});
    rd_chk(rtsc_pkg::OFF_IRQ_STATUS, 32'h1, "status gpt");
    check_pin("irq cleared", 5'h00, {4'h0, irq});
    rd_chk(rtsc_pkg::OFF_GPT_COUNT, 32'h0, "gpt zero");
    core.wr(rtsc_pkg::OFF_GPT_CTRL, 32'h0);
    core.wr(rtsc_pkg::OFF_GPT_LOAD, 32'h2);
    core.wr(rtsc_pkg::OFF_GPT_CTRL, 32'h303);
    repeat (3) @(posedge clock);
    #1;
    check_pin("irq prescale", 5'h00, {4'h0, irq});
    for (i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clock);
    #1;
    check_pin("irq prescaled", 5'h01, {4'h0, irq});
    rd_chk(rtsc_pkg::OFF_IRQ_STATUS, 32'h1, "status pre");
    for (i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clock);
    #1;
    check_pin("irq reload", 5'h01, {4'h0, irq});
    core.wr(rtsc_pkg::OFF_GPT_CTRL, 32'h0);
    rd_chk(rtsc_pkg::OFF_IRQ_STATUS, 32'h1, "status reload");
    $display("test general timer done");
  endtask : t_gpt

  task automatic t_wut();
    core.wr(rtsc_pkg::OFF_IRQ_MASK, 32'h2);
    core.wr(rtsc_pkg::OFF_WUT_LOAD, 32'h14);
    core.wr(rtsc_pkg::OFF_WUT_CTRL, 32'h1);
    core.wr(rtsc_pkg::OFF_CTRL, 32'h8);
    #1;
    check_pin("pmode sleep", 5'h02, {3'h0, pmode});
    check_pin("ls clock", 5'h00, {4'h0, core_clk_sel_hs});
    for (i = 0; i < 40 && pmode !== rtsc_pkg::PM_RUN; i++) begin
      @(posedge clock);
      #1;
    end
    check_pin("wut wake", 5'h01, {4'h0, irq});
    rd_chk(rtsc_pkg::OFF_IRQ_STATUS, 32'h2, "status wut");
    core.wr(rtsc_pkg::OFF_WUT_CTRL, 32'h0);
    core.wr(rtsc_pkg::OFF_CTRL, 32'h1);
    #1;
    check_pin("hs clock", 5'h01, {4'h0, hs_osc_en});
    $display("test wake-up timer done");
  endtask : t_wut

  task automatic t_attach();
    core.wr(rtsc_pkg::OFF_IRQ_MASK, 32'h0);
    core.wr(rtsc_pkg::OFF_CTRL, 32'h8);
    @(posedge clock);
    attach_detect <= 1'b1;
    seen = 1'b0;
    for (i = 0; i < 6 && pmode !== rtsc_pkg::PM_RUN; i++) begin
      #1;
      seen = seen | (wake_req === 1'b1);
      @(posedge clock);
    end
    attach_detect <= 1'b0;
    #1;
    check_pin("wake_req", 5'h01, {4'h0, seen});
    check_pin("attach run", 5'h00, {3'h0, pmode});
    check_pin("irq masked", 5'h00, {4'h0, irq});
    rd_chk(rtsc_pkg::OFF_IRQ_STATUS, 32'h4, "status attach");
    $display("test attach wake done");
  endtask : t_attach

  task automatic t_freeze();
    core.wr(rtsc_pkg::OFF_CTRL, 32'h5);
    core.wr(rtsc_pkg::OFF_CTRL, 32'hd);
    #1;
    check_pin("pmode idle", 5'h01, {3'h0, pmode});
    check_pin("idle clock", 5'h01, {4'h0, core_clk_sel_hs});
    core.wr(rtsc_pkg::OFF_CTRL, 32'h1);
    core.wr(rtsc_pkg::OFF_WUT_LOAD, 32'h30);
    core.wr(rtsc_pkg::OFF_WUT_CTRL, 32'h1);
    clk_en <= 1'b0;
    repeat (10) @(posedge clock);
    clk_en <= 1'b1;
    rd_chk(rtsc_pkg::OFF_WUT_COUNT, 32'h2f, "wut frozen");
    core.wr(rtsc_pkg::OFF_WUT_CTRL, 32'h0);
    $display("test clock enable done");
  endtask : t_freeze

  task automatic t_supply();
    @(posedge clock);
    supply_ok <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check_pin("por scope", 5'h1f, rst_out);
    @(posedge clock);
    supply_ok <= 1'b1;
    wait_rst_clear();
    rd_chk(rtsc_pkg::OFF_RST_CAUSE, 32'h1, "cause por");
    rd_chk(rtsc_pkg::OFF_CTRL, 32'h1, "ctrl cleared");
    $display("test supply reset done");
  endtask : t_supply

  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  initial begin
    #(3000 * 50);
    err_total++;
    give_verdict();
  end

  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    supply_ok = 1'b1;
    ls_tick = 1'b0;
    attach_detect = 1'b0;
    tick_cnt = 3'h0;
    err_total = 0;
    n_compared = 0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    t_reset();
    t_wd_lock();
    t_wd_timeout();
    t_swrst();
    t_gpt();
    t_wut();
    t_attach();
    t_freeze();
    t_supply();
    give_verdict();
  end
endmodule : testbench
